// >>> rtl/gwp_wake.sv
/*
 * gwp_wake: per-pin wake enable and trigger polarity, wake request and
 * interrupt, with software access over AXI4-Lite.
 * assumes: pin mux, power state and serial memory loader sit outside.
 */
// The AXI4-Lite slave port was left to the implementer.
// Overview of operation
// - pin wakes only with its enable set
// - polarity zero triggers low, one high
// - alternate-function pins never raise wake
// - link-up on pin 7 in first and fourth suspend states
// - enable default loaded from serial memory
// - bus or light reset restores loaded image
// - reset protection shields wake enable field
`timescale 1ns/1ps
module gwp_wake
    import gwp_pkg::*;
#(
    parameter bit LINK_VARIANT = 1'b1,  // variant with link-up and loadable defaults
    parameter int NPIN = gwp_pkg::GWP_PINS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NPIN-1:0] gpio_in,
    input wire logic [NPIN-1:0] pin_is_gpio,
    input wire logic suspend_state_first,
    input wire logic suspend_state_fourth,
    input wire logic link_up_event,
    input wire logic bus_reset,
    input wire logic image_present,
    input wire logic image_load,
    input wire logic [15:0] image_wake_bytes,
    output logic wake_request,
    output logic link_up_wake,
    output logic irq
);
    import gwp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [NPIN-1:0] pin_wake_enable, next_wake_enable;    // enable field
    logic [NPIN-1:0] pin_trigger_polarity, next_polarity;  // polarity field
    logic link_up_signal_enable, next_link_en;
    logic [NPIN-1:0] image_wake, next_image;  // last value loaded from memory
    logic reset_protect, next_protect;        // protection of the enable field
    logic [NPIN-1:0] status, next_status;     // sticky pin events
    logic [NPIN-1:0] int_enable, next_int_enable;
    logic [NPIN-1:0] pins;                    // synchronised pins
    logic [NPIN-1:0] hit;                     // level matches polarity
    logic [NPIN-1:0] qualified;               // hit on an enabled gpio pin
    logic light_reset;                        // software light reset strobe
    logic link_ok;

    // bus channel state
    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    logic do_write;

    // byte-lane merge used for the wake, interrupt enable and clear words
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser
    gwp_sync #(.W(NPIN)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(gpio_in),
        .sync_out(pins)
    );

    // pin event qualification
    always_comb begin
        hit = ~(pins ^ pin_trigger_polarity);
        qualified = hit & pin_wake_enable & pin_is_gpio;
        link_ok = LINK_VARIANT && link_up_signal_enable &&
                  (suspend_state_first || suspend_state_fourth) &&
                  pin_wake_enable[GWP_LINK_PIN] && pin_is_gpio[GWP_LINK_PIN];
    end

    assign wake_request = |qualified;
    assign link_up_wake = link_ok && link_up_event;
    assign irq = |(status & int_enable);

    ////////////////////////////////////////////////////////////////////////
    // write channel acceptance: address and data in either order
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            // response follows once both halves are in
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            case (aw_addr)
                OFS_WAKE, OFS_CLR, OFS_IEN, OFS_CTRL, OFS_STAT: next_bresp = RESP_OKAY;
                default: next_bresp = RESP_SLVERR;
            endcase
        end else if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
    end

    assign s_axi_awready = !aw_held && !bvalid;
    assign s_axi_wready = !w_held && !bvalid;
    assign do_write = aw_held && w_held && !bvalid;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign light_reset = do_write && aw_addr == OFS_CTRL && w_strb[0] && w_data[POS_LIGHT_RESET];

    ////////////////////////////////////////////////////////////////////////
    // register contents
    always_comb begin
        logic [31:0] word;
        logic [31:0] ien_word;  // interrupt enable word after the lane merge
        logic [31:0] clr_word;  // clear mask after the lane merge
        word = merge({link_up_signal_enable, 4'h0, pin_trigger_polarity, 5'h00,
                      pin_wake_enable}, w_data, w_strb);
        ien_word = merge({21'h0, int_enable}, w_data, w_strb);
        clr_word = merge(32'h0, w_data, w_strb);
        next_wake_enable = pin_wake_enable;
        next_polarity = pin_trigger_polarity;
        next_link_en = link_up_signal_enable;
        next_image = image_wake;
        next_protect = reset_protect;
        next_int_enable = int_enable;
        next_status = status;
        // memory load: unused high bits ignored, absent memory gives zero
        if (image_load) begin
            next_image = image_present ? image_wake_bytes[NPIN-1:0] : '0;
            next_wake_enable = LINK_VARIANT && image_present ?
                               image_wake_bytes[NPIN-1:0] : '0;
        end else if ((bus_reset || light_reset) && !(LINK_VARIANT && reset_protect)) begin
            // protected field keeps its content across these resets;
            // with no memory fitted the field falls back to all zeros
            next_wake_enable = (LINK_VARIANT && image_present) ? image_wake : '0;
        end
        if (do_write && aw_addr == OFS_WAKE) begin
            next_wake_enable = word[POS_WAKE +: NPIN];
            next_polarity = word[POS_POL +: NPIN];
            next_link_en = LINK_VARIANT ? word[POS_LINK] : 1'b0;
        end
        if (do_write && aw_addr == OFS_IEN) begin
            next_int_enable = ien_word[NPIN-1:0];
        end
        if (do_write && aw_addr == OFS_CTRL && w_strb[0]) begin
            next_protect = w_data[POS_PROT];
        end
        // clear first, so a same-cycle event wins
        if (do_write && aw_addr == OFS_CLR) begin
            next_status = status & ~clr_word[NPIN-1:0];
        end
        next_status = next_status | (hit & pin_is_gpio);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_wake_enable <= '0;
            pin_trigger_polarity <= RST_POL;
            link_up_signal_enable <= RST_LINK;
            image_wake <= '0;
            reset_protect <= 1'b0;
            int_enable <= '0;
            status <= '0;
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            pin_wake_enable <= next_wake_enable;
            pin_trigger_polarity <= next_polarity;
            link_up_signal_enable <= next_link_en;
            image_wake <= next_image;
            reset_protect <= next_protect;
            int_enable <= next_int_enable;
            status <= next_status;
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel: one cycle after the address is taken
    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            case (s_axi_araddr)
                OFS_WAKE: next_rdata = {link_up_signal_enable, 4'h0, pin_trigger_polarity,
                                        5'h00, pin_wake_enable};
                OFS_STAT: next_rdata = {21'h0, status};
                OFS_CLR: next_rdata = 32'h0;  // write-only
                OFS_IEN: next_rdata = {21'h0, int_enable};
                OFS_CTRL: next_rdata = {31'h0, reset_protect};
                default: begin
                    next_rdata = 32'h0;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end else if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= RESP_OKAY;
        end else begin
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    assign s_axi_arready = !rvalid;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_wake_needs_enable: assert property (@(posedge aclk) disable iff (!aresetn)
        wake_request |-> |(pin_wake_enable & pin_is_gpio))
        else $error("wake without enabled gpio pin");
    chk_polarity_match: assert property (@(posedge aclk) disable iff (!aresetn)
        wake_request |-> |(~(pins ^ pin_trigger_polarity) & pin_wake_enable))
        else $error("wake level does not match polarity");
    chk_field_layout: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_WAKE) |=>
        (s_axi_rdata[26:16] == $past(pin_trigger_polarity)))
        else $error("polarity field misplaced");
    chk_alt_function: assert property (@(posedge aclk) disable iff (!aresetn)
        wake_request |-> |(~(pins ^ pin_trigger_polarity) & pin_wake_enable & pin_is_gpio))
        else $error("alternate function pin woke device");
    chk_link_state: assert property (@(posedge aclk) disable iff (!aresetn)
        link_up_wake |-> (suspend_state_first || suspend_state_fourth) &&
        link_up_signal_enable)
        else $error("link-up outside suspend or disabled");
    chk_image_load: assert property (@(posedge aclk) disable iff (!aresetn)
        (image_load && !image_present) |=> pin_wake_enable == '0)
        else $error("absent memory left nonzero enables");
    chk_reset_restore: assert property (@(posedge aclk) disable iff (!aresetn)
        (bus_reset && !reset_protect && !image_load && !do_write) |=>
        pin_wake_enable == ($past(image_present) ? $past(image_wake) : '0))
        else $error("bus reset did not restore image");
    chk_protect_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        (bus_reset && reset_protect && !image_load && !do_write) |=> $stable(pin_wake_enable))
        else $error("protected field disturbed by reset");
    chk_wake_or: assert property (@(posedge aclk) disable iff (!aresetn)
        (|(~(pins ^ pin_trigger_polarity) & pin_wake_enable & pin_is_gpio)) |-> wake_request)
        else $error("qualified pin did not request wake");
endmodule // gwp_wake

// >>> rtl/gwp_pkg.sv
/*
 * gwp_pkg: constants for the pin wake enable and polarity block.
 * assumes: a single 20 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package gwp_pkg;
    localparam int GWP_PINS = 11;               // general purpose pins
    localparam int GWP_LINK_PIN = 7;            // pin that can carry link-up
    localparam logic [7:0] OFS_WAKE = 8'h64;    // enable / polarity word
    localparam logic [7:0] OFS_STAT = 8'h80;    // sticky wake status
    localparam logic [7:0] OFS_CLR = 8'h84;     // write-one-to-clear status
    localparam logic [7:0] OFS_IEN = 8'h88;     // interrupt enable
    localparam logic [7:0] OFS_CTRL = 8'h8c;    // reset protection, light reset
    localparam int POS_WAKE = 0;                // wake enable field base bit
    localparam int POS_POL = 16;                // polarity field base bit
    localparam int POS_LINK = 31;               // link-up enable bit
    localparam int POS_PROT = 0;                // ctrl: reset protection
    localparam int POS_LIGHT_RESET = 1;                // ctrl: light reset strobe
    localparam logic [10:0] RST_POL = 11'h000;  // polarity reset value
    localparam logic RST_LINK = 1'b0;           // link-up enable reset value
    localparam logic [1:0] RESP_OKAY = 2'b00;   // axi okay
    localparam logic [1:0] RESP_SLVERR = 2'b10; // axi unmapped answer
endpackage

// >>> rtl/gwp_sync.sv
/*
 * gwp_sync: three-stage synchroniser bank for the pin inputs, with a
 * change accepted only once stages two and three agree.
 * assumes: pins are asynchronous to aclk.
 */
`timescale 1ns/1ps
module gwp_sync #(
    parameter int W = 11
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] s1, s2, s3, next_out;

    // stable value moves only when the two later stages agree
    always_comb begin
        next_out = sync_out;
        for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
                next_out[i] = s3[i];
            end
        end
    end

    // the first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            sync_out <= '0;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            sync_out <= next_out;
        end
    end
endmodule // gwp_sync

// >>> testbench/gwp_pin_model.sv
/*
 * gwp_pin_model: far side of the general purpose pins, the levels that
 * outside circuits drive onto them.
 * assumes: the bench names the wanted level; the design synchronises it.
 */
`timescale 1ns/1ps
module gwp_pin_model (
    input wire logic aclk,
    input wire logic [10:0] drive_level,
    output logic [10:0] gpio_in
);
    ////////////////////////////////////////////////////////////////////////
    // lines move 7 ns after the edge, so the design sees a truly async change
    always @(posedge aclk) begin
        gpio_in <= #7 drive_level;
    end
endmodule // gwp_pin_model

// >>> testbench/tb_top.sv
/*
 * tb_top: register-level bench for the pin wake enable and polarity block.
 * assumes: gwp_pkg, gwp_wake and gwp_pin_model are compiled before it.
 */
`timescale 1ns/1ps
module tb_top;
    import gwp_pkg::*;
    logic aclk, aresetn;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic [10:0] drive_level, gpio_in, pin_is_gpio;
    logic susp1, susp4, link_ev, bus_reset, img_present, img_load;
    logic [15:0] img_bytes;
    logic wake_request, link_up_wake, irq;
    int errors, tests_run, cycles; // mismatch, compare and cycle counts

    ////////////////////////////////////////////////////////////////////////
    gwp_wake u_gwp_wake (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .gpio_in(gpio_in),
        .pin_is_gpio(pin_is_gpio), .suspend_state_first(susp1),
        .suspend_state_fourth(susp4), .link_up_event(link_ev), .bus_reset(bus_reset),
        .image_present(img_present), .image_load(img_load),
        .image_wake_bytes(img_bytes), .wake_request(wake_request),
        .link_up_wake(link_up_wake), .irq(irq));
    gwp_pin_model u_gwp_pin_model (.aclk(aclk), .drive_level(drive_level),
        .gpio_in(gpio_in));

    // 50 ns period
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // a hang ends the run as a failure; the sequence needs well under 2000 cycles
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("compares %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // both halves offered together, each dropped at its own handshake edge
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        resp = bresp;
    endtask

    // rready stays high for the whole run, so only arvalid moves here
    task automatic axi_read(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rd = rdata;
        resp = rresp;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        axi_read(a);
        check(rd & m, e);
    endtask

    task automatic pulse_bus_reset;
        bus_reset <= 1'b1;
        @(posedge aclk);
        bus_reset <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        aresetn = 1'b0;
        {awaddr, araddr, wdata, awvalid, wvalid, arvalid} = '0;
        wstrb = 4'hf;
        bready = 1'b1;
        rready = 1'b1;
        drive_level = 11'h7ff;   // pins idle high, so polarity zero sees no match
        pin_is_gpio = 11'h7ff;
        {susp1, susp4, link_ev, bus_reset, img_present, img_load} = '0;
        img_bytes = 16'h0000;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(OFS_WAKE, 32'hffffffff, 32'h00000000);
        axi_write(OFS_WAKE, 32'hffffffff);
        check(32'(resp), 32'(RESP_OKAY));
        rd_chk(OFS_WAKE, 32'hffffffff, 32'h87ff07ff);
        tick(8);
        check(32'(wake_request), 32'h1);
        axi_write(OFS_WAKE, 32'h00000000);
        axi_write(OFS_CLR, 32'h000007ff);
        rd_chk(OFS_STAT, 32'h000007ff, 32'h0);
        // pin 3 alone: enable, polarity and level turned one at a time
        axi_write(OFS_WAKE, 32'h00080008);
        tick(2);
        check(32'(wake_request), 32'h1);
        axi_write(OFS_WAKE, 32'h00080000);
        tick(2);
        check(32'(wake_request), 32'h0);
        axi_write(OFS_WAKE, 32'h00000008);
        tick(2);
        check(32'(wake_request), 32'h0);
        drive_level <= 11'h7f7;
        tick(8);
        check(32'(wake_request), 32'h1);
        pin_is_gpio <= 11'h7f7;
        tick(2);
        check(32'(wake_request), 32'h0);
        pin_is_gpio <= 11'h7ff;
        tick(2);
        // sticky status, enable mask, clear losing to a standing match
        rd_chk(OFS_STAT, 32'h000007ff, 32'h8);
        axi_write(OFS_IEN, 32'h00000004);
        check(32'(irq), 32'h0);
        axi_write(OFS_IEN, 32'h00000008);
        tick(1);
        check(32'(irq), 32'h1);
        axi_write(OFS_CLR, 32'h00000008);
        rd_chk(OFS_STAT, 32'h000007ff, 32'h8);
        drive_level <= 11'h7ff;
        tick(8);
        axi_write(OFS_CLR, 32'h00000008);
        rd_chk(OFS_STAT, 32'h000007ff, 32'h0);
        check(32'(irq), 32'h0);
        // link-up through pin 7 in either suspend state only
        axi_write(OFS_WAKE, 32'h80800080);
        susp1 <= 1'b1;
        link_ev <= 1'b1;
        tick(2);
        check(32'(link_up_wake), 32'h1);
        susp1 <= 1'b0;
        tick(2);
        check(32'(link_up_wake), 32'h0);
        susp4 <= 1'b1;
        tick(2);
        check(32'(link_up_wake), 32'h1);
        susp4 <= 1'b0;
        link_ev <= 1'b0;
        // image load, restore on resets, reset protection
        img_present <= 1'b1;
        img_bytes <= 16'hffff;
        img_load <= 1'b1;
        @(posedge aclk);
        img_load <= 1'b0;
        rd_chk(OFS_WAKE, 32'h0000ffff, 32'h000007ff);
        axi_write(OFS_WAKE, 32'h00000000);
        pulse_bus_reset();
        rd_chk(OFS_WAKE, 32'h0000ffff, 32'h000007ff);
        axi_write(OFS_CTRL, 32'h00000001);
        axi_write(OFS_WAKE, 32'h00000000);
        pulse_bus_reset();
        rd_chk(OFS_WAKE, 32'h0000ffff, 32'h00000000);
        // strobe and protect-clear in one word: the old protection still shields
        axi_write(OFS_CTRL, 32'h00000002);
        rd_chk(OFS_WAKE, 32'h0000ffff, 32'h00000000);
        axi_write(OFS_CTRL, 32'h00000002);
        rd_chk(OFS_WAKE, 32'h0000ffff, 32'h000007ff);
        img_present <= 1'b0;
        pulse_bus_reset();
        rd_chk(OFS_WAKE, 32'h0000ffff, 32'h00000000);
        // a load with no memory fitted zeroes a nonzero field
        axi_write(OFS_WAKE, 32'h000007ff);
        img_load <= 1'b1;
        @(posedge aclk);
        img_load <= 1'b0;
        rd_chk(OFS_WAKE, 32'h0000ffff, 32'h00000000);
        // an unmapped word answers with an error and no data
        axi_read(8'h10);
        check(32'(resp), 32'(RESP_SLVERR));
        check(rd, 32'h00000000);
        complete_run();
    end
endmodule // tb_top
